// file: hdl/absolute_encoder_multiturn.sv
`timescale 1ns/1ns
`default_nettype none
module absolute_encoder_multiturn
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic encoder_usage_select,
  input wire logic [15:0] multiturn_limit_setting,
  input wire logic [31:0] zero_point_offset,
  input wire logic [15:0] enc_limit,
  input wire logic enc_limit_valid,
  input wire logic [31:0] encoder_position,
  input wire logic rev_step_pos,
  input wire logic rev_step_neg,
  input wire logic enc_backup_fail,
  input wire logic enc_checksum_fail,
  input wire logic enc_monitor_fail,
  input wire logic servo_on,
  input wire logic adjust_command,
  input wire logic [7:0] adjust_code,
  input wire logic adjust_rewrite,
  input wire logic operator_multiturn_rewrite,
  input wire logic alarm_clear_command,
  output logic usage_absolute,
  output logic [15:0] active_limit,
  output logic [15:0] multiturn_count,
  output logic [31:0] machine_position,
  output logic setup_done,
  output logic command_refused,
  output logic enc_clear,
  output logic enc_limit_write,
  output logic [15:0] enc_limit_wdata,
  output logic backup_alarm,
  output logic checksum_alarm,
  output logic monitor_alarm,
  output logic multiturn_limit_mismatch_alarm,
  output logic refused_alarm,
  output logic alarm_code_out_a,
  output logic alarm_code_out_b,
  output logic alarm_code_out_c
);
  // power-up capture of offline settings
  abs_enc_pkg::start_e state_r, state_nxt;
  logic usage_r, usage_nxt;
  logic [15:0] limit_r, limit_nxt;
  logic [31:0] offset_r, offset_nxt;
  logic mismatch_r, mismatch_nxt;

  // clamp the offset into its documented signed range
  function automatic logic [31:0] clamp_offset(input logic [31:0] v);
    if (!v[31] && v > abs_enc_pkg::OFFSET_MAX)
      clamp_offset = abs_enc_pkg::OFFSET_MAX;
    else if (v[31] && v < abs_enc_pkg::OFFSET_MIN)
      clamp_offset = abs_enc_pkg::OFFSET_MIN;
    else
      clamp_offset = v;
  endfunction : clamp_offset

  always_comb
  begin
    state_nxt = state_r;
    usage_nxt = usage_r;
    limit_nxt = limit_r;
    offset_nxt = offset_r;
    mismatch_nxt = mismatch_r;
    unique case (state_r)
      abs_enc_pkg::ST_CAPTURE:
      begin
        // settings are taken once per reset so later edits wait
        // for the next power cycle
        usage_nxt = encoder_usage_select;
        limit_nxt = multiturn_limit_setting;
        offset_nxt = clamp_offset(zero_point_offset);
        if (encoder_usage_select == abs_enc_pkg::USAGE_ABSOLUTE)
          state_nxt = abs_enc_pkg::ST_WAIT_ENC;
        else
          state_nxt = abs_enc_pkg::ST_RUN;
      end
      abs_enc_pkg::ST_WAIT_ENC:
        if (enc_limit_valid)
        begin
          mismatch_nxt = (enc_limit != limit_r);
          state_nxt = abs_enc_pkg::ST_RUN;
        end
      abs_enc_pkg::ST_RUN:
        state_nxt = abs_enc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= abs_enc_pkg::ST_CAPTURE;
      usage_r <= abs_enc_pkg::USAGE_ABSOLUTE;
      limit_r <= abs_enc_pkg::LIMIT_RESET;
      offset_r <= abs_enc_pkg::OFFSET_RESET;
      mismatch_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      usage_r <= usage_nxt;
      limit_r <= limit_nxt;
      offset_r <= offset_nxt;
      mismatch_r <= mismatch_nxt;
    end
  end

  // commands and alarms
  logic running;
  logic absolute_run;
  logic adj_valid;
  logic setup_req;
  logic rewrite_req;
  logic setup_ok;
  logic rewrite_ok;
  logic backup_r, backup_nxt;
  logic checksum_r, checksum_nxt;
  logic monitor_r, monitor_nxt;
  logic refused_r, refused_nxt;
  logic setup_done_r, setup_done_nxt;
  logic refused_p_r, refused_p_nxt;
  logic wr_r, wr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [2:0] code_r, code_nxt;
  logic [31:0] pos_r, pos_nxt;
  logic [15:0] count;

  assign running = (state_r == abs_enc_pkg::ST_RUN);
  assign absolute_run = running && (usage_r == abs_enc_pkg::USAGE_ABSOLUTE);
  assign adj_valid = adjust_command &&
    (adjust_code == abs_enc_pkg::ADJUST_CODE);
  assign setup_req = adj_valid && !adjust_rewrite;
  assign rewrite_req = (adj_valid && adjust_rewrite) ||
    operator_multiturn_rewrite;
  assign setup_ok = setup_req && absolute_run && !servo_on;
  assign rewrite_ok = rewrite_req && absolute_run && mismatch_r;

  always_comb
  begin
    // a new failure in the same cycle as a clear is kept
    backup_nxt = (backup_r && !setup_ok) || enc_backup_fail;
    checksum_nxt = (checksum_r && !setup_ok) || enc_checksum_fail;
    monitor_nxt = monitor_r || enc_monitor_fail;
    refused_p_nxt = (setup_req && !setup_ok) ||
      (rewrite_req && !rewrite_ok);
    // ordinary clear only reaches the refused-command alarm
    refused_nxt = (refused_r && !alarm_clear_command) || refused_p_nxt;
    setup_done_nxt = setup_ok;
    wr_nxt = rewrite_ok;
    // the new limit only acts after the next power cycle
    wdata_nxt = rewrite_ok ? limit_r : wdata_r;
    if (monitor_r)
      code_nxt = abs_enc_pkg::CODE_MONITOR;
    else if (backup_r)
      code_nxt = abs_enc_pkg::CODE_BACKUP;
    else if (checksum_r)
      code_nxt = abs_enc_pkg::CODE_CHECKSUM;
    else if (mismatch_r)
      code_nxt = abs_enc_pkg::CODE_MISMATCH;
    else if (refused_r)
      code_nxt = abs_enc_pkg::CODE_REFUSED;
    else
      code_nxt = abs_enc_pkg::CODE_NONE;
    pos_nxt = encoder_position + offset_r;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      backup_r <= 1'b0;
      checksum_r <= 1'b0;
      monitor_r <= 1'b0;
      refused_r <= 1'b0;
      refused_p_r <= 1'b0;
      setup_done_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= abs_enc_pkg::LIMIT_RESET;
      code_r <= abs_enc_pkg::CODE_NONE;
      pos_r <= abs_enc_pkg::OFFSET_RESET;
    end
    else
    begin
      backup_r <= backup_nxt;
      checksum_r <= checksum_nxt;
      monitor_r <= monitor_nxt;
      refused_r <= refused_nxt;
      refused_p_r <= refused_p_nxt;
      setup_done_r <= setup_done_nxt;
      wr_r <= wr_nxt;
      wdata_r <= wdata_nxt;
      code_r <= code_nxt;
      pos_r <= pos_nxt;
    end
  end

  // incremental use keeps no multiturn data
  multiturn_counter u_count
  (
    .clk(clk),
    .resetn(resetn),
    .enable(absolute_run),
    .clear(setup_ok),
    .step_pos(rev_step_pos),
    .step_neg(rev_step_neg),
    .limit(limit_r),
    .count(count)
  );

  assign usage_absolute = (usage_r == abs_enc_pkg::USAGE_ABSOLUTE);
  assign active_limit = limit_r;
  assign multiturn_count = count;
  assign machine_position = pos_r;
  assign setup_done = setup_done_r;
  assign enc_clear = setup_done_r;
  assign command_refused = refused_p_r;
  assign enc_limit_write = wr_r;
  assign enc_limit_wdata = wdata_r;
  assign backup_alarm = backup_r;
  assign checksum_alarm = checksum_r;
  assign monitor_alarm = monitor_r;
  assign multiturn_limit_mismatch_alarm = mismatch_r;
  assign refused_alarm = refused_r;
  assign alarm_code_out_a = code_r[2];
  assign alarm_code_out_b = code_r[1];
  assign alarm_code_out_c = code_r[0];
endmodule : absolute_encoder_multiturn
`default_nettype wire

// file: hdl/multiturn_counter.sv
`timescale 1ns/1ns
`default_nettype none
module multiturn_counter
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic clear,
  input wire logic step_pos,
  input wire logic step_neg,
  input wire logic [15:0] limit,
  output logic [15:0] count
);
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic signed_mode;

  assign signed_mode = (limit == abs_enc_pkg::LIMIT_SIGNED);

  always_comb
  begin
    count_nxt = count_r;
    if (clear || !enable)
      count_nxt = abs_enc_pkg::COUNT_RESET;
    else if (step_pos && !step_neg)
    begin
      // signed mode wraps 32767 to -32768 through two's complement
      if (!signed_mode && count_r == limit)
        count_nxt = abs_enc_pkg::COUNT_RESET;
      else
        count_nxt = count_r + 16'h0001;
    end
    else if (step_neg && !step_pos)
    begin
      if (!signed_mode && count_r == abs_enc_pkg::COUNT_RESET)
        count_nxt = limit;
      else
        count_nxt = count_r - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count_r <= abs_enc_pkg::COUNT_RESET;
    else
      count_r <= count_nxt;
  end

  assign count = count_r;
endmodule : multiturn_counter
`default_nettype wire

// file: include/abs_enc_pkg.sv
`default_nettype none
package abs_enc_pkg;
  localparam int LIMIT_W = 16;
  localparam int POS_W = 32;
  localparam int CODE_W = 8;
  // usage selector encodings
  localparam logic USAGE_ABSOLUTE = 1'h0;
  localparam logic USAGE_INCREMENTAL = 1'h1;
  // limit value that selects signed multiturn counting
  localparam logic [15:0] LIMIT_SIGNED = 16'hFFFF;
  localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] OFFSET_RESET = 32'h00000000;
  localparam logic [31:0] OFFSET_MAX = 32'h3FFFFFFF;
  localparam logic [31:0] OFFSET_MIN = 32'hC0000001;
  localparam logic [7:0] ADJUST_CODE = 8'h3E;
  // alarm code patterns, bit 2 = out_a, bit 1 = out_b, bit 0 = out_c
  // a zero bit means the pin is driven low (active)
  localparam logic [2:0] CODE_NONE = 3'h7;
  localparam logic [2:0] CODE_MISMATCH = 3'h2;
  localparam logic [2:0] CODE_MONITOR = 3'h0;
  localparam logic [2:0] CODE_BACKUP = 3'h4;
  localparam logic [2:0] CODE_CHECKSUM = 3'h1;
  localparam logic [2:0] CODE_REFUSED = 3'h6;
  typedef enum logic [1:0] {ST_CAPTURE, ST_WAIT_ENC, ST_RUN} start_e;
endpackage : abs_enc_pkg
`default_nettype wire

// file: testbench/abs_enc_sva.sv
`timescale 1ns/1ns
`default_nettype none
module abs_enc_sva
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic servo_on,
  input wire logic adjust_command,
  input wire logic [7:0] adjust_code,
  input wire logic adjust_rewrite,
  input wire logic rev_step_pos,
  input wire logic rev_step_neg,
  input wire logic enc_backup_fail,
  input wire logic enc_limit_valid,
  input wire logic usage_absolute,
  input wire logic [15:0] active_limit,
  input wire logic [15:0] multiturn_count,
  input wire logic setup_done,
  input wire logic command_refused,
  input wire logic enc_limit_write,
  input wire logic backup_alarm,
  input wire logic checksum_alarm,
  input wire logic monitor_alarm,
  input wire logic multiturn_limit_mismatch_alarm,
  input wire logic alarm_code_out_a,
  input wire logic alarm_code_out_b,
  input wire logic alarm_code_out_c
);
  wire logic [2:0] code_w = {alarm_code_out_a, alarm_code_out_b,
    alarm_code_out_c};
  // a setup in the same cycle forces the count to zero, so it is excluded
  wire logic up_w = rev_step_pos && !rev_step_neg && !adjust_command;
  wire logic dn_w = rev_step_neg && !rev_step_pos && !adjust_command;
  // the count is held at zero until the power-up limit compare has run
  logic [1:0] age_r;
  logic live_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      age_r <= 2'h0;
      live_r <= 1'b0;
    end
    else
    begin
      if (age_r != 2'h2)
        age_r <= age_r + 2'h1;
      if (age_r != 2'h0 && enc_limit_valid)
        live_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence adj_req;
    adjust_command && adjust_code == abs_enc_pkg::ADJUST_CODE;
  endsequence
  mismatch_code_a: assert property (multiturn_limit_mismatch_alarm &&
    !monitor_alarm && !backup_alarm && !checksum_alarm
    |=> code_w == abs_enc_pkg::CODE_MISMATCH) else $error("bad code");
  refuse_servo_a: assert property (adj_req ##0 (servo_on &&
    !adjust_rewrite) |=> command_refused && !setup_done) else $error("ran");
  rewrite_gate_a: assert property (adj_req ##0 (adjust_rewrite &&
    !multiturn_limit_mismatch_alarm) |=> command_refused && !enc_limit_write)
    else $error("rewrite let through");
  backup_keep_a: assert property (backup_alarm && !adjust_command
    |=> backup_alarm) else $error("backup alarm lost");
  setup_clear_a: assert property (setup_done &&
    !$past(enc_backup_fail) |-> !backup_alarm) else $error("not cleared");
  monitor_hold_a: assert property (monitor_alarm |=> monitor_alarm)
    else $error("monitor alarm lost");
  wrap_up_a: assert property (up_w && usage_absolute &&
    active_limit != 16'hFFFF && multiturn_count == active_limit
    |=> multiturn_count == 16'h0000) else $error("no wrap to zero");
  wrap_down_a: assert property (dn_w && usage_absolute && live_r &&
    active_limit != 16'hFFFF && multiturn_count == 16'h0000
    |=> multiturn_count == $past(active_limit)) else $error("no wrap");
  signed_wrap_a: assert property (up_w && usage_absolute &&
    active_limit == 16'hFFFF && multiturn_count == 16'h7FFF
    |=> multiturn_count == 16'h8000) else $error("bad signed wrap");
endmodule : abs_enc_sva
bind absolute_encoder_multiturn abs_enc_sva u_abs_enc_sva (.*);
`default_nettype wire

// file: testbench/enc_model.sv
`timescale 1ns/1ns
`default_nettype none
module enc_model
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic enc_limit_write,
  input wire logic [15:0] enc_limit_wdata,
  output logic [15:0] enc_limit,
  output logic enc_limit_valid
);
  // battery-backed memory survives the amplifier power cycle: no reset
  logic [15:0] store_r = 16'hFFFF;
  logic [1:0] wake_r;
  always @(posedge clk)
    if (enc_limit_write)
      store_r <= enc_limit_wdata;
  always @(posedge clk or negedge resetn)
    if (!resetn)
      wake_r <= 2'h0;
    else if (wake_r != 2'h3)
      wake_r <= wake_r + 2'h1;
  assign enc_limit_valid = (wake_r == 2'h3);
  // before valid the lines carry the inverse, so a stale read cannot pass
  assign enc_limit = enc_limit_valid ? store_r : ~store_r;
endmodule : enc_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  logic clk = 1'b0, resetn = 1'b0, encoder_usage_select = 1'b0;
  logic servo_on = 1'b0, adjust_rewrite = 1'b0;
  logic [15:0] multiturn_limit_setting = 16'hFFFF;
  logic [31:0] zero_point_offset = 32'hFFFFFFFB, encoder_position = 32'h0;
  logic [7:0] adjust_code = 8'h3E, pl = 8'h00;
  wire logic rev_step_pos, rev_step_neg, enc_backup_fail, enc_checksum_fail;
  wire logic enc_monitor_fail, adjust_command, operator_multiturn_rewrite;
  wire logic alarm_clear_command, enc_limit_valid, usage_absolute;
  wire logic [15:0] enc_limit, active_limit, multiturn_count, enc_limit_wdata;
  wire logic [31:0] machine_position;
  wire logic setup_done, command_refused, enc_clear, enc_limit_write;
  wire logic backup_alarm, checksum_alarm, monitor_alarm, refused_alarm;
  wire logic multiturn_limit_mismatch_alarm;
  wire logic alarm_code_out_a, alarm_code_out_b, alarm_code_out_c;
  int fail_count = 0, num_checks = 0;
  assign {rev_step_pos, rev_step_neg, enc_backup_fail, enc_checksum_fail,
    enc_monitor_fail, adjust_command, operator_multiturn_rewrite,
    alarm_clear_command} = pl;
  absolute_encoder_multiturn u_absolute_encoder_multiturn (.*);
  enc_model u_enc_model (.*);
  always #25 clk = ~clk;
  task automatic pulse(input logic [7:0] p);
    @(posedge clk) pl <= p;
    @(posedge clk) pl <= 8'h00;
    #1;
  endtask : pulse
  task automatic power(input logic u, input logic [15:0] l);
    @(posedge clk) resetn <= 1'b0;
    encoder_usage_select <= u;
    multiturn_limit_setting <= l;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask : power
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    power(1'b0, 16'h0009);
    `CHK(multiturn_limit_mismatch_alarm, 1'b1)
    `CHK({alarm_code_out_a, alarm_code_out_b, alarm_code_out_c}, 3'h2)
    `CHK(active_limit, 16'h0009)
    pulse(8'h02);
    `CHK({enc_limit_write, enc_limit_wdata}, 17'h10009)
    power(1'b0, 16'h0009);
    `CHK(multiturn_limit_mismatch_alarm, 1'b0)
    `CHK(usage_absolute, 1'b1)
    `CHK({alarm_code_out_a, alarm_code_out_b, alarm_code_out_c}, 3'h7)
    pulse(8'h02);
    `CHK({command_refused, enc_limit_write}, 2'h2)
    @(posedge clk) adjust_rewrite <= 1'b1;
    pulse(8'h04);
    `CHK({command_refused, enc_limit_write}, 2'h2)
    @(posedge clk) adjust_rewrite <= 1'b0;
    pulse(8'h40);
    `CHK(multiturn_count, 16'h0009)
    pulse(8'h80);
    `CHK(multiturn_count, 16'h0000)
    // limit 9 = ten turns per load cycle, so ten steps come back to zero
    @(posedge clk) pl <= 8'h80;
    repeat (10) @(posedge clk);
    pl <= 8'h00;
    #1;
    `CHK(multiturn_count, 16'h0000)
    @(posedge clk) encoder_position <= 32'h00000100;
    multiturn_limit_setting <= 16'h0005;
    repeat (2) @(posedge clk);
    #1;
    `CHK(machine_position, 32'h000000FB)
    `CHK(active_limit, 16'h0009)
    $display("test 1 done");
    @(posedge clk) servo_on <= 1'b1;
    pulse(8'h04);
    `CHK({command_refused, setup_done}, 2'h2)
    `CHK(refused_alarm, 1'b1)
    pulse(8'h30);
    pulse(8'h01);
    `CHK({backup_alarm, checksum_alarm}, 2'h3)
    `CHK(refused_alarm, 1'b0)
    @(posedge clk) servo_on <= 1'b0;
    pulse(8'h04);
    `CHK({setup_done, enc_clear, backup_alarm, checksum_alarm}, 4'hC)
    @(posedge clk) adjust_code <= 8'h3D;
    pulse(8'h04);
    `CHK({setup_done, command_refused}, 2'h0)
    @(posedge clk) adjust_code <= 8'h3E;
    pulse(8'h08);
    pulse(8'h01);
    pulse(8'h04);
    `CHK(monitor_alarm, 1'b1)
    @(posedge clk) zero_point_offset <= 32'h7FFFFFFF;
    power(1'b1, 16'h0009);
    `CHK({monitor_alarm, usage_absolute}, 2'h0)
    `CHK(machine_position, 32'h400000FF)
    @(posedge clk) encoder_usage_select <= 1'b0;
    pulse(8'h80);
    `CHK({usage_absolute, multiturn_count}, 17'h00000)
    $display("test 2 done");
    power(1'b0, 16'hFFFF);
    pulse(8'h02);
    @(posedge clk) adjust_rewrite <= 1'b1;
    pulse(8'h04);
    `CHK({enc_limit_write, enc_limit_wdata}, 17'h1FFFF)
    @(posedge clk) adjust_rewrite <= 1'b0;
    power(1'b0, 16'hFFFF);
    `CHK(multiturn_limit_mismatch_alarm, 1'b0)
    pulse(8'h40);
    `CHK(multiturn_count, 16'hFFFF)
    @(posedge clk) pl <= 8'h80;
    repeat (32768) @(posedge clk);
    pl <= 8'h00;
    #1;
    `CHK(multiturn_count, 16'h7FFF)
    pulse(8'h80);
    `CHK(multiturn_count, 16'h8000)
    $display("test 3 done");
    summarize();
  end
  initial
  begin
    #3000000;
    fail_count++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
